// ===== src/ifpirq_params.svh
// Purpose: register offsets, field positions, reset values and counts for the infoframe irq block
// Assumes: 8-bit control port, byte-wide registers
// Notes:   definitions only
`ifndef IFPIRQ_PARAMS_SVH
`define IFPIRQ_PARAMS_SVH

// register offsets on the control port
`define IFPIRQ_OFF_CLEAR        8'h69
`define IFPIRQ_OFF_MASK_TWO     8'h6A
`define IFPIRQ_OFF_MASK_ONE     8'h6B
`define IFPIRQ_OFF_RAW_STATUS   8'h6C

// reset values
`define IFPIRQ_MASK_RESET       8'h00
`define IFPIRQ_BYTE_ZERO        8'h00

// event bit positions, shared by clear, mask and latched vectors
`define IFPIRQ_BIT_REC_CODE2    7
`define IFPIRQ_BIT_REC_CODE1    6
`define IFPIRQ_BIT_CONTENT_PROT 5
`define IFPIRQ_BIT_VENDOR       4
`define IFPIRQ_BIT_MPEG_SOURCE  3
`define IFPIRQ_BIT_SOURCE_PROD  2
`define IFPIRQ_BIT_AUDIO_FRAME  1
`define IFPIRQ_BIT_VIDEO_INFO   0

// raw status register field positions
`define IFPIRQ_BIT_CS_VALID     7
`define IFPIRQ_BIT_INT_MUTE     6
`define IFPIRQ_BIT_AV_MUTE      5
`define IFPIRQ_BIT_LAYOUT_CHG   4

// vsync leading edges after the last frame at which raw status drops
`define IFPIRQ_VIDEO_VS_LIMIT   4'h8
`define IFPIRQ_AUDIO_VS_LIMIT   4'h4

`endif

// ===== src/ifpirq_pkg.sv
// Purpose: shared types for the infoframe irq block
// Assumes: constants live in ifpirq_params.svh
// Notes:   types only
package ifpirq_pkg;
  typedef logic [7:0] ifpirq_byte_type;
  typedef logic [3:0] ifpirq_count_type;
  typedef logic [3:0] ifpirq_nibble_type;
endpackage

// ===== src/ifpirq_timer_if.sv
// Purpose: carrier between the irq top and a vsync timeout timer
// Assumes: single clock domain
// Notes:   restart and vsyncRise are one-cycle pulses, expire is a pulse
`timescale 1ns/1ps
interface ifpirq_timer_if;
  logic restart;
  logic vsyncRise;
  logic expire;
  modport owner (output restart, output vsyncRise, input expire);
  modport timer (input restart, input vsyncRise, output expire);
endinterface

// ===== src/ifpirq_vsync_timer.sv
// Purpose: counts vsync leading edges after the last received frame
// Assumes: vsyncRise is already a one-cycle edge pulse on mclk
// Notes:   expire pulses once on the edge that reaches the limit
`timescale 1ns/1ps
`include "ifpirq_params.svh"
module ifpirq_vsync_timer
  import ifpirq_pkg::*;
#(
  parameter ifpirq_pkg::ifpirq_count_type LIMIT = `IFPIRQ_VIDEO_VS_LIMIT
) (
  input  wire logic   mclk,
  input  wire logic   rst_n,
  ifpirq_timer_if.timer tmr
);
  import ifpirq_pkg::*;

  ifpirq_count_type countReg;
  ifpirq_count_type countNext;
  logic             armedReg;
  logic             armedNext;
  logic             expireReg;
  logic             expireNext;

  // a new frame restarts the wait; restart wins over an edge in the same cycle
  always_comb begin
    countNext  = countReg;
    armedNext  = armedReg;
    expireNext = 1'b0;
    if (tmr.restart) begin
      countNext = '0;
      armedNext = 1'b1;
    end else if (tmr.vsyncRise && armedReg) begin
      if (countReg + 4'h1 == LIMIT) begin
        expireNext = 1'b1;
        armedNext  = 1'b0;
        countNext  = '0;
      end else begin
        countNext = countReg + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      countReg  <= 4'h0;
      armedReg  <= 1'b0;
      expireReg <= 1'b0;
    end else begin
      countReg  <= countNext;
      armedReg  <= armedNext;
      expireReg <= expireNext;
    end
  end

  assign tmr.expire = expireReg;
endmodule

// ===== src/ifpirq_top.sv
// Purpose: latched event flags, self-clearing clears and two masked interrupt lines
//          for infoframe and packet detection events
// Assumes: all event inputs come from logic on mclk; registers reached over a byte-wide
//          control port with one-cycle write and read strobes
// Notes:   read data appears one cycle after the read strobe; unmapped reads give zero
`timescale 1ns/1ps
`include "ifpirq_params.svh"

module ifpirq_top
  import ifpirq_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic [7:0]                  regAddr,
  input  wire ifpirq_pkg::ifpirq_byte_type regWrData,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output      ifpirq_pkg::ifpirq_byte_type regRdData,
  input  wire logic                        vsync,
  input  wire logic                        packetDetectReset,
  input  wire logic                        linkReset,
  input  wire logic                        videoInfoFrameRx,
  input  wire logic                        audioFrameRx,
  input  wire logic                        recCode2Raw,
  input  wire logic                        recCode1Raw,
  input  wire logic                        contentProtectRaw,
  input  wire logic                        vendorFrameRaw,
  input  wire logic                        mpegSourceRaw,
  input  wire logic                        sourceProductRaw,
  input  wire ifpirq_pkg::ifpirq_nibble_type packetFlagClear,
  input  wire logic                        csDataValid,
  input  wire logic                        internalMute,
  input  wire logic                        avMuteRx,
  input  wire logic                        audioLayoutChanged,
  output      ifpirq_pkg::ifpirq_byte_type eventLatched,
  output      logic                        videoInfoFrameRaw,
  output      logic                        audioFrameRaw,
  output      logic                        irqLineOne,
  output      logic                        irqLineTwo
);
  import ifpirq_pkg::*;

  // timing at the ports, counted from the edge that takes an input, which is edge 0:
  //   mask write          -> mask after edge 0, lines follow it after edge 1
  //   clear write         -> internal pulse after edge 0, flag and lines low after edge 1
  //   packet flag clear   -> flag and lines low after edge 0
  //   raw level change    -> flag and lines high after edge 0
  //   frame pulse         -> raw status after edge 0, flag and lines after edge 1
  //   last vsync edge     -> timer expiry after edge 0, raw status low after edge 1
  //   packet detect reset -> video and audio raw status low after edge 0
  //   av mute pulse       -> sticky raw bit high after edge 0
  //   read strobe         -> read data after edge 0, held until the next read
  // the control port has no wait states: every strobe is taken at the edge that sees it.
  // every output comes from a flop, so a host may sample lines and read data anywhere
  //   in the cycle that follows.
  // set wins over clear for every flag, so an event landing on its own clear is never lost;
  //   the price is that a flag may come back at once and software must read again.
  // flags latch even with both masks off, so software can poll them with the lines idle;
  //   flags 7:4 have their clear register elsewhere and their clears come on packetFlagClear

  // one place decides what a strobe at an offset means
  function automatic logic regHit(input logic [7:0] addr, input logic [7:0] offset);
    regHit = (addr == offset);
  endfunction

  // both lines reduce their flags the same way
  function automatic logic lineLevel(input ifpirq_byte_type flags, input ifpirq_byte_type mask);
    lineLevel = |(flags & mask);
  endfunction

  // control port state
  ifpirq_byte_type   maskTwoReg;
  ifpirq_byte_type   maskTwoNext;
  ifpirq_byte_type   maskOneReg;
  ifpirq_byte_type   maskOneNext;
  ifpirq_nibble_type clearPulseReg;
  ifpirq_nibble_type clearPulseNext;
  ifpirq_byte_type   rdDataReg;
  ifpirq_byte_type   rdDataNext;
  ifpirq_byte_type   rawStatus;

  // event path state
  ifpirq_byte_type   latchedReg;
  ifpirq_byte_type   latchedNext;
  ifpirq_byte_type   rawPrevReg;
  ifpirq_byte_type   rawPrevNext;
  ifpirq_byte_type   rawNow;
  ifpirq_byte_type   flagSet;
  ifpirq_byte_type   flagClear;
  logic              videoRawReg;
  logic              videoRawNext;
  logic              audioRawReg;
  logic              audioRawNext;
  logic              avMuteReg;
  logic              avMuteNext;
  logic              vsyncPrevReg;
  logic              vsyncPrevNext;
  logic              vsyncRise;
  logic              irqOneReg;
  logic              irqOneNext;
  logic              irqTwoReg;
  logic              irqTwoNext;

  // one carrier per timer so each restarts on its own frame
  ifpirq_timer_if videoTmr ();
  ifpirq_timer_if audioTmr ();

  // register writes; clear bits live one cycle only so a stuck one cannot mask new events
  // writes to the raw status or to an unmapped offset fall through and change nothing
  always_comb begin
    maskTwoNext    = maskTwoReg;
    maskOneNext    = maskOneReg;
    clearPulseNext = 4'h0;
    if (regWr && regHit(regAddr, `IFPIRQ_OFF_MASK_TWO)) begin
      maskTwoNext = regWrData;
    end
    if (regWr && regHit(regAddr, `IFPIRQ_OFF_MASK_ONE)) begin
      maskOneNext = regWrData;
    end
    if (regWr && regHit(regAddr, `IFPIRQ_OFF_CLEAR)) begin
      clearPulseNext = regWrData[3:0];
    end
  end

  // raw status byte; the lower four bits belong to other blocks and read zero
  always_comb begin
    rawStatus                         = `IFPIRQ_BYTE_ZERO;
    rawStatus[`IFPIRQ_BIT_CS_VALID]   = csDataValid;
    rawStatus[`IFPIRQ_BIT_INT_MUTE]   = internalMute;
    rawStatus[`IFPIRQ_BIT_AV_MUTE]    = avMuteReg;
    rawStatus[`IFPIRQ_BIT_LAYOUT_CHG] = audioLayoutChanged;
  end

  // read mux; the clear register is write-only and reads back zero
  // read data is held between reads so a slow host may pick it up late
  always_comb begin
    rdDataNext = rdDataReg;
    if (regRd) begin
      if (regHit(regAddr, `IFPIRQ_OFF_MASK_TWO)) begin
        rdDataNext = maskTwoReg;
      end else if (regHit(regAddr, `IFPIRQ_OFF_MASK_ONE)) begin
        rdDataNext = maskOneReg;
      end else if (regHit(regAddr, `IFPIRQ_OFF_RAW_STATUS)) begin
        rdDataNext = rawStatus;
      end else begin
        rdDataNext = `IFPIRQ_BYTE_ZERO;
      end
    end
  end

  // control port registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      maskTwoReg    <= `IFPIRQ_MASK_RESET;
      maskOneReg    <= `IFPIRQ_MASK_RESET;
      clearPulseReg <= 4'h0;
      rdDataReg     <= `IFPIRQ_BYTE_ZERO;
    end else begin
      maskTwoReg    <= maskTwoNext;
      maskOneReg    <= maskOneNext;
      clearPulseReg <= clearPulseNext;
      rdDataReg     <= rdDataNext;
    end
  end

  // vsync edge detect; the previous level resets low, which is harmless because
  // both timers stay disarmed until their first frame arrives
  always_comb begin
    vsyncPrevNext = vsync;
    vsyncRise     = vsync && !vsyncPrevReg;
  end

  // frame arrivals restart the timers, vsync edges advance them
  assign videoTmr.restart   = videoInfoFrameRx;
  assign videoTmr.vsyncRise = vsyncRise;
  assign audioTmr.restart   = audioFrameRx;
  assign audioTmr.vsyncRise = vsyncRise;

  // video info raw status falls on the eighth vsync edge with no new frame
  ifpirq_vsync_timer #(
    .LIMIT (`IFPIRQ_VIDEO_VS_LIMIT)
  ) videoTimer (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tmr   (videoTmr.timer)
  );

  // audio frame raw status falls on the fourth vsync edge with no new frame
  ifpirq_vsync_timer #(
    .LIMIT (`IFPIRQ_AUDIO_VS_LIMIT)
  ) audioTimer (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tmr   (audioTmr.timer)
  );

  // video raw detection status; a frame arriving with a drop condition keeps the status set
  always_comb begin
    videoRawNext = videoRawReg;
    if (videoTmr.expire || packetDetectReset || clearPulseReg[`IFPIRQ_BIT_VIDEO_INFO]) begin
      videoRawNext = 1'b0;
    end
    if (videoInfoFrameRx) begin
      videoRawNext = 1'b1;
    end
  end

  // audio raw status; the audio clear bit only drops the flag, never this status
  always_comb begin
    audioRawNext = audioRawReg;
    if (audioTmr.expire || packetDetectReset) begin
      audioRawNext = 1'b0;
    end
    if (audioFrameRx) begin
      audioRawNext = 1'b1;
    end
  end

  // av mute is sticky; only a link reset drops it, and a new indication in that cycle wins
  always_comb begin
    avMuteNext = avMuteReg;
    if (linkReset) begin
      avMuteNext = 1'b0;
    end
    if (avMuteRx) begin
      avMuteNext = 1'b1;
    end
  end

  // gather raw levels in the same bit order as the masks
  // the two frame bits use the timed raw status, the rest come straight from the detectors
  always_comb begin
    rawNow                               = `IFPIRQ_BYTE_ZERO;
    rawNow[`IFPIRQ_BIT_REC_CODE2]        = recCode2Raw;
    rawNow[`IFPIRQ_BIT_REC_CODE1]        = recCode1Raw;
    rawNow[`IFPIRQ_BIT_CONTENT_PROT]     = contentProtectRaw;
    rawNow[`IFPIRQ_BIT_VENDOR]           = vendorFrameRaw;
    rawNow[`IFPIRQ_BIT_MPEG_SOURCE]      = mpegSourceRaw;
    rawNow[`IFPIRQ_BIT_SOURCE_PROD]      = sourceProductRaw;
    rawNow[`IFPIRQ_BIT_AUDIO_FRAME]      = audioRawReg;
    rawNow[`IFPIRQ_BIT_VIDEO_INFO]       = videoRawReg;
  end

  // latched flags: any raw change except a software drop of the video raw sets, clears drop, set wins over a clear in the same cycle
  always_comb begin
    rawPrevNext = rawNow;
    // a software drop of the video raw is not a detection event: the remembered level
    // follows the drop, so the next compare sees no change and the flag stays clear
    if (clearPulseReg[`IFPIRQ_BIT_VIDEO_INFO] && !videoInfoFrameRx) begin
      rawPrevNext[`IFPIRQ_BIT_VIDEO_INFO] = 1'b0;
    end
    flagSet     = rawNow ^ rawPrevReg;
    flagClear   = {packetFlagClear, clearPulseReg};
    latchedNext = (latchedReg & ~flagClear) | flagSet;
    irqOneNext  = lineLevel(latchedNext, maskOneReg);
    irqTwoNext  = lineLevel(latchedNext, maskTwoReg);
  end

  // event path registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      videoRawReg  <= 1'b0;
      audioRawReg  <= 1'b0;
      avMuteReg    <= 1'b0;
      vsyncPrevReg <= 1'b0;
      rawPrevReg   <= `IFPIRQ_BYTE_ZERO;
      latchedReg   <= `IFPIRQ_BYTE_ZERO;
      irqOneReg    <= 1'b0;
      irqTwoReg    <= 1'b0;
    end else begin
      videoRawReg  <= videoRawNext;
      audioRawReg  <= audioRawNext;
      avMuteReg    <= avMuteNext;
      vsyncPrevReg <= vsyncPrevNext;
      rawPrevReg   <= rawPrevNext;
      latchedReg   <= latchedNext;
      irqOneReg    <= irqOneNext;
      irqTwoReg    <= irqTwoNext;
    end
  end

  // outputs all come straight from flops
  assign regRdData         = rdDataReg;
  assign eventLatched      = latchedReg;
  assign videoInfoFrameRaw = videoRawReg;
  assign audioFrameRaw     = audioRawReg;
  assign irqLineOne        = irqOneReg;
  assign irqLineTwo        = irqTwoReg;
endmodule

// ===== verif/ifpirq_top_chk.sv
// Purpose: port-level checks for ifpirq_top
// Assumes: masks are shadowed from control port writes
// Notes:   bound from the bench top file
`timescale 1ns/1ps
`include "ifpirq_params.svh"
module ifpirq_top_chk
  import ifpirq_pkg::*;
(
  input wire logic            mclk,
  input wire logic            rst_n,
  input wire logic [7:0]      regAddr,
  input wire ifpirq_byte_type regWrData,
  input wire logic            regWr,
  input wire logic            regRd,
  input wire ifpirq_byte_type regRdData,
  input wire logic            videoInfoFrameRx,
  input wire logic            audioFrameRx,
  input wire logic            mpegSourceRaw,
  input wire logic            csDataValid,
  input wire logic            internalMute,
  input wire logic            audioLayoutChanged,
  input wire ifpirq_byte_type eventLatched,
  input wire logic            videoInfoFrameRaw,
  input wire logic            audioFrameRaw,
  input wire logic            irqLineOne,
  input wire logic            irqLineTwo
);
  ifpirq_byte_type maskOne_reg;
  ifpirq_byte_type maskTwo_reg;
  ifpirq_byte_type clrWr;
  // clear bits written this cycle, zero otherwise
  assign clrWr = (regWr && regAddr == `IFPIRQ_OFF_CLEAR) ? regWrData : 8'h00;
  // shadow masks so line checks need no probe inside the block
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      maskOne_reg <= 8'h00;
      maskTwo_reg <= 8'h00;
    end else if (regWr && regAddr == `IFPIRQ_OFF_MASK_ONE) begin
      maskOne_reg <= regWrData;
    end else if (regWr && regAddr == `IFPIRQ_OFF_MASK_TWO) begin
      maskTwo_reg <= regWrData;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // mask writes take a cycle to reach the lines, so only stable masks are judged
  line_one_a: assert property ($stable(maskOne_reg) |-> irqLineOne == |(eventLatched & maskOne_reg))
    else $error("line one disagrees with flags");
  line_two_a: assert property ($stable(maskTwo_reg) |-> irqLineTwo == |(eventLatched & maskTwo_reg))
    else $error("line two disagrees with flags");
  flag_set_a: assert property ($changed(mpegSourceRaw) |=> eventLatched[3])
    else $error("mpeg flag missed a change");
  flag_hold_a: assert property ((($past(eventLatched) & ~eventLatched & 8'h0F & ~$past(clrWr, 2)) == 8'h00))
    else $error("flag dropped without a clear");
  video_set_a: assert property (videoInfoFrameRx |=> videoInfoFrameRaw)
    else $error("video raw not set by frame");
  audio_set_a: assert property (audioFrameRx |=> audioFrameRaw)
    else $error("audio raw not set by frame");
  video_clear_a: assert property (clrWr[0] && !videoInfoFrameRx ##1 (!videoInfoFrameRx) [*2] |=> !videoInfoFrameRaw && !eventLatched[0])
    else $error("video clear left raw or flag");
  raw_read_a: assert property (regRd && regAddr == `IFPIRQ_OFF_RAW_STATUS |=> (regRdData & 8'hDF) == {$past(csDataValid), $past(internalMute), 1'b0, $past(audioLayoutChanged), 4'h0})
    else $error("raw status read wrong");
  clear_read_a: assert property (regRd && regAddr == `IFPIRQ_OFF_CLEAR |=> regRdData == 8'h00)
    else $error("clear register read not zero");
  mask_read_a: assert property (regRd && regAddr == `IFPIRQ_OFF_MASK_ONE |=> regRdData == $past(maskOne_reg))
    else $error("line one mask read wrong");
  cover property (irqLineOne);
  cover property (irqLineTwo);
  cover property (clrWr[0]);
endmodule

// ===== verif/ifpirq_host.sv
// Purpose: host model on the control port
// Assumes: strobes change on falling mclk
// Notes:   released lines show the inverse of the last value
`timescale 1ns/1ps
module ifpirq_host
  import ifpirq_pkg::*;
(
  input  wire logic            mclk,
  output      logic [7:0]      regAddr,
  output      ifpirq_byte_type regWrData,
  output      logic            regWr,
  output      logic            regRd,
  input  wire ifpirq_byte_type regRdData,
  input  wire ifpirq_byte_type eventLatched
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // one-cycle write strobe, lines scrambled once it has been taken
  task automatic wr(input logic [7:0] a, input ifpirq_byte_type d);
    @(negedge mclk);
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(negedge mclk);
    regWr = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
  // read data lands one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output ifpirq_byte_type d);
    @(negedge mclk);
    regAddr = a;
    regRd = 1'b1;
    @(negedge mclk);
    regRd = 1'b0;
    regAddr = ~a;
    @(negedge mclk);
    d = regRdData;
  endtask
  // service: sample the latched flags, then clear those of bits 3:0 that are set
  task automatic service();
    wr(`IFPIRQ_OFF_CLEAR, eventLatched & 8'h0F);
  endtask
endmodule

// ===== verif/ifpirq_top_tb.sv
// Purpose: self-checking bench for ifpirq_top
// Assumes: inputs change on falling mclk
// Notes:   masks split events between the two lines
`timescale 1ns/1ps
`include "ifpirq_params.svh"
module ifpirq_top_tb;
  import ifpirq_pkg::*;
  localparam ifpirq_byte_type MTWO = 8'h5A;
  localparam ifpirq_byte_type MONE = 8'hA5;
  logic mclk, rst_n, vsync, packetDetectReset, linkReset, videoInfoFrameRx, audioFrameRx;
  logic recCode2Raw, recCode1Raw, contentProtectRaw, vendorFrameRaw, mpegSourceRaw, sourceProductRaw;
  logic csDataValid, internalMute, avMuteRx, audioLayoutChanged, regWr, regRd;
  logic irqLineOne, irqLineTwo, videoInfoFrameRaw, audioFrameRaw;
  logic [7:2] raw;
  logic [7:0] regAddr;
  ifpirq_nibble_type packetFlagClear;
  ifpirq_byte_type regWrData, regRdData, eventLatched, rdVal;
  int mismatches, comparisons;
  assign {recCode2Raw, recCode1Raw, contentProtectRaw, vendorFrameRaw, mpegSourceRaw, sourceProductRaw} = raw;
  ifpirq_top dut (.*);
  ifpirq_host host (.*);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input ifpirq_byte_type seen, input ifpirq_byte_type exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input ifpirq_byte_type exp);
    host.rd(a, rdVal);
    chk(rdVal, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // each vsync is two cycles high, two low
  task automatic vs(input int n);
    repeat (n) begin
      vsync = 1'b1;
      cyc(2);
      vsync = 1'b0;
      cyc(2);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog, far beyond the two hundred or so cycles the sequence needs
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
  initial begin
    {vsync, packetDetectReset, linkReset, videoInfoFrameRx, audioFrameRx, raw} = '0;
    {csDataValid, internalMute, avMuteRx, audioLayoutChanged} = 4'h0;
    packetFlagClear = 4'h0;
    rst_n = 1'b0;
    cyc(4);
    rst_n = 1'b1;
    // reset values, refused writes and unmapped reads
    rdchk(`IFPIRQ_OFF_MASK_TWO, 8'h00);
    rdchk(`IFPIRQ_OFF_MASK_ONE, 8'h00);
    host.wr(`IFPIRQ_OFF_RAW_STATUS, 8'hFF);
    rdchk(`IFPIRQ_OFF_RAW_STATUS, 8'h00);
    rdchk(`IFPIRQ_OFF_CLEAR, 8'h00);
    rdchk(8'h70, 8'h00);
    host.wr(`IFPIRQ_OFF_MASK_TWO, MTWO);
    host.wr(`IFPIRQ_OFF_MASK_ONE, MONE);
    rdchk(`IFPIRQ_OFF_MASK_TWO, MTWO);
    rdchk(`IFPIRQ_OFF_MASK_ONE, MONE);
    // every detector event: set, route to one line only, clear, set again on fall
    for (int b = 2; b < 8; b++) begin
      raw[b] = 1'b1;
      cyc(2);
      chk(eventLatched, 8'h01 << b);
      chk({6'h0, irqLineTwo, irqLineOne}, {6'h0, MTWO[b], MONE[b]});
      if (b < 4) begin
        host.wr(`IFPIRQ_OFF_CLEAR, 8'h00);
        cyc(2);
        chk(eventLatched, 8'h01 << b);
        host.service();
      end else begin
        packetFlagClear = 4'h1 << (b - 4);
        cyc(1);
        packetFlagClear = 4'h0;
      end
      cyc(3);
      chk({irqLineTwo, irqLineOne, eventLatched[5:0]}, 8'h00);
      raw[b] = 1'b0;
      cyc(2);
      chk(eventLatched, 8'h01 << b);
      packetFlagClear = (b < 4) ? 4'h0 : 4'h1 << (b - 4);
      cyc(1);
      packetFlagClear = 4'h0;
      if (b < 4) host.service();
      cyc(3);
    end
    // video frame on line one, dropped at the eighth vsync edge
    videoInfoFrameRx = 1'b1;
    cyc(1);
    videoInfoFrameRx = 1'b0;
    cyc(3);
    chk({videoInfoFrameRaw, irqLineOne, irqLineTwo, eventLatched[4:0]}, 8'hC1);
    // flag left set: clearing it here would drop the raw status as well
    vs(7);
    chk({videoInfoFrameRaw, eventLatched[6:0]}, 8'h81);
    vs(1);
    chk({videoInfoFrameRaw, eventLatched[6:0]}, 8'h01);
    host.service();
    videoInfoFrameRx = 1'b1;
    cyc(1);
    videoInfoFrameRx = 1'b0;
    cyc(3);
    host.service();
    cyc(3);
    chk({videoInfoFrameRaw, eventLatched[6:0]}, 8'h00);
    // audio frame on line two, dropped at the fourth vsync edge
    audioFrameRx = 1'b1;
    cyc(1);
    audioFrameRx = 1'b0;
    cyc(3);
    chk({audioFrameRaw, irqLineOne, irqLineTwo, eventLatched[4:0]}, 8'hA2);
    host.service();
    vs(3);
    chk({audioFrameRaw, eventLatched[6:0]}, 8'h80);
    vs(1);
    chk({audioFrameRaw, eventLatched[6:0]}, 8'h02);
    host.service();
    // raw status levels, sticky av mute until link reset
    {csDataValid, internalMute, avMuteRx, audioLayoutChanged} = 4'hF;
    cyc(1);
    avMuteRx = 1'b0;
    rdchk(`IFPIRQ_OFF_RAW_STATUS, 8'hF0);
    {csDataValid, internalMute, audioLayoutChanged} = 3'h0;
    rdchk(`IFPIRQ_OFF_RAW_STATUS, 8'h20);
    linkReset = 1'b1;
    cyc(1);
    linkReset = 1'b0;
    rdchk(`IFPIRQ_OFF_RAW_STATUS, 8'h00);
    // packet detection reset drops the video raw status
    videoInfoFrameRx = 1'b1;
    cyc(1);
    videoInfoFrameRx = 1'b0;
    chk({7'h0, videoInfoFrameRaw}, 8'h01);
    packetDetectReset = 1'b1;
    cyc(3);
    packetDetectReset = 1'b0;
    chk({7'h0, videoInfoFrameRaw}, 8'h00);
    end_sim();
  end
endmodule
bind ifpirq_top ifpirq_top_chk chk (.*);
